//--- hdl/isp_pkg.sv
// Package with shared constants and a delay helper function of the serial programming port
package isp_pkg;
  // ===========================================================================
  // Instruction bytes
  localparam logic [7:0] OP_WRCFG      = 8'hAC;
  localparam logic [7:0] SUB_ENABLE    = 8'h53;
  localparam logic [7:0] SUB_ERASE     = 8'h80;
  localparam logic [7:0] SUB_LOCK      = 8'hE0;
  localparam logic [7:0] SUB_FUSE_LO   = 8'hA0;
  localparam logic [7:0] SUB_FUSE_HI   = 8'hA8;
  localparam logic [7:0] SUB_FUSE_EXT  = 8'hA4;
  localparam logic [7:0] OP_POLL       = 8'hF0;
  localparam logic [7:0] OP_EXT_ADDR   = 8'h4D;
  localparam logic [7:0] OP_LOAD_HI    = 8'h48;
  localparam logic [7:0] OP_LOAD_LO    = 8'h40;
  localparam logic [7:0] OP_EE_LOAD    = 8'hC1;
  localparam logic [7:0] OP_RD_HI      = 8'h28;
  localparam logic [7:0] OP_RD_LO      = 8'h20;
  localparam logic [7:0] OP_EE_RD      = 8'hA0;
  localparam logic [7:0] OP_RD_LOCKHI  = 8'h58;
  localparam logic [7:0] OP_RD_FUSE    = 8'h50;
  localparam logic [7:0] OP_RD_SIG     = 8'h30;
  localparam logic [7:0] OP_RD_CAL     = 8'h38;
  localparam logic [7:0] OP_PAGE_WR    = 8'h4C;
  localparam logic [7:0] OP_EE_WR      = 8'hC0;
  localparam logic [7:0] OP_EE_PAGE_WR = 8'hC2;
  localparam logic [7:0] SEL_HI        = 8'h08;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam logic [7:0] ERASED        = 8'hFF;
  // ===========================================================================
  // Frame layout and timing
  localparam int FRAME_BITS     = 32;
  localparam int CLK_HZ         = 25_000_000;
  localparam int SCK_PHASE_MIN  = 3;            // CPU cycles, above 2 at 25 MHz
  localparam int SCK_HALF       = 4;            // Host divider half period
  localparam int RST_PULSE_CYC  = 2;
  localparam int POWERUP_US     = 20_000;
  localparam int POWERUP_CYC    = POWERUP_US * (CLK_HZ / 1_000_000);
  localparam int FLASH_WD_US    = 2_600;
  localparam int EEPROM_WD_US   = 3_600;
  localparam int ERASE_WD_US    = 10_500;
  localparam int CONFIG_WD_US   = 4_500;
  localparam int FLASH_WD_CYC   = FLASH_WD_US * (CLK_HZ / 1_000_000);
  localparam int EEPROM_WD_CYC  = EEPROM_WD_US * (CLK_HZ / 1_000_000);
  localparam int ERASE_WD_CYC   = ERASE_WD_US * (CLK_HZ / 1_000_000);
  localparam int CONFIG_WD_CYC  = CONFIG_WD_US * (CLK_HZ / 1_000_000);
  // ===========================================================================
  // Reset values of configuration bytes, arbitrary
  localparam logic [7:0] LOCK_RST    = 8'hFF;
  localparam logic [7:0] FUSE_LO_RST = 8'h62;
  localparam logic [7:0] FUSE_HI_RST = 8'hD9;
  localparam logic [7:0] FUSE_EX_RST = 8'hFF;
  localparam logic [7:0] CAL_VALUE   = 8'h80;
  // Signature bytes, arbitrary values
  localparam logic [7:0] SIG0        = 8'h5A;
  localparam logic [7:0] SIG1        = 8'h01;
  localparam logic [7:0] SIG2        = 8'h02;

  function automatic int wd_cycles(input int us, input int scale);
    return (us * (CLK_HZ / 1_000_000)) / scale;
  endfunction
endpackage

//--- hdl/isp_link_if.sv
// Interface joining the programmer and the device over the serial link
`timescale 1ns/1ps
interface isp_link_if;
  logic rst_n_pin;  // Target reset, low while programming
  logic sck;        // Serial clock from programmer
  logic mosi;       // Programmer to device data
  logic miso;       // Device to programmer data
  modport prog (output rst_n_pin, output sck, output mosi, input miso);
  modport dev  (input rst_n_pin, input sck, input mosi, output miso);
endinterface

//--- hdl/isp_buf2.sv
// Two-entry valid/ready buffer for 32-bit frames
`timescale 1ns/1ps
module isp_buf2 #(
  parameter int WIDTH = 32
) (
  input  wire logic             clk_sys,  // System clock
  input  wire logic             resetn,   // Synchronous reset, low
  input  wire logic [WIDTH-1:0] in_data,  // Write data
  input  wire logic             in_valid, // Write request
  output logic                  in_ready, // Space available
  output logic      [WIDTH-1:0] out_data, // Head word
  output logic                  out_valid,// Head valid
  input  wire logic             out_ready // Reader takes head
);
  logic [WIDTH-1:0] mem_reg [2];
  logic             wp_reg;
  logic             rp_reg;
  logic [1:0]       cnt_reg;
  logic             push;
  logic             pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rp_reg];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        wp_reg <= ~wp_reg;
      end
      if (pop) begin
        rp_reg <= ~rp_reg;
      end
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // isp_buf2

//--- hdl/isp_dev.sv
// Device end: serial programming port with memories and configuration bytes
// Behaviour
// - Program only in reset after enable
// - EEPROM byte write erases first, self-timed
// - Chip erase fills flash and EEPROM FF
// - Host keeps SCK phases above minimum
// - Sample MOSI on SCK rising edge
// - Shift MISO on SCK falling edge
// - Host powers up with reset, SCK low
// - Host waits 20 ms before enable
// - Enable AC 53 echoes 53 in byte three
// - Chip erase AC 80, then delay
// - Poll F0 returns pending flag in LSB
// - Load page low 40, high 48
// - Host loads low byte before high
// - Commit flash page with 4C
// - Host waits flash delay after commit
// - EEPROM byte write C0 with delay
// - EEPROM page C1 load, C2 commit
// - Flash read 20 low, 28 high
// - EEPROM read A0 returns byte
// - Lock, fuse, signature, calibration reads
// - Config writes AC E0/A0/A8/A4
// - 4D captures extended address byte
`timescale 1ns/1ps
module isp_dev #(
  parameter int FLASH_AW   = 8,   // Flash word address bits
  parameter int EE_AW      = 6,   // EEPROM address bits
  parameter int PAGE_W     = 2,   // Word bits within a page
  parameter int TIME_SCALE = 1    // Divides write delays for simulation
) (
  input  wire logic  clk_sys,    // Device CPU clock
  input  wire logic  resetn,     // Synchronous reset, low
  isp_link_if.dev    link,       // Serial link pins
  output logic       prog_en,    // Programming mode enabled
  output logic       busy        // Operation pending flag
);
  // ===========================================================================
  // Pin synchronisers
  logic [1:0] sck_s_reg, mosi_s_reg, rst_s_reg;
  logic       sck_d_reg;
  logic       sck_rise, sck_fall, in_reset;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sck_s_reg  <= 2'h0;
      mosi_s_reg <= 2'h0;
      rst_s_reg  <= 2'h3;
      sck_d_reg  <= 1'b0;
    end else begin
      sck_s_reg  <= {sck_s_reg[0], link.sck};
      mosi_s_reg <= {mosi_s_reg[0], link.mosi};
      rst_s_reg  <= {rst_s_reg[0], link.rst_n_pin};
      sck_d_reg  <= sck_s_reg[1];
    end
  end

  assign sck_rise = sck_s_reg[1] && !sck_d_reg;
  assign sck_fall = !sck_s_reg[1] && sck_d_reg;
  assign in_reset = !rst_s_reg[1];

  // ===========================================================================
  // Frame shifter
  logic [31:0] sh_reg;
  logic [4:0]  bit_reg;
  logic [7:0]  out_reg;
  logic        miso_reg;
  logic        frame_done;
  logic [31:0] frame;

  assign frame_done = sck_rise && (bit_reg == 5'd31);
  assign frame      = {sh_reg[30:0], mosi_s_reg[1]};

  always_ff @(posedge clk_sys) begin
    if (!resetn || !in_reset) begin
      bit_reg <= 5'd0;
      sh_reg  <= 32'h0;
    end else if (sck_rise) begin
      sh_reg  <= frame;
      bit_reg <= bit_reg + 5'd1;
    end
  end

  // ===========================================================================
  // Memories and configuration
  logic [7:0]  flash_lo [2**FLASH_AW];
  logic [7:0]  flash_hi [2**FLASH_AW];
  logic [7:0]  eeprom [2**EE_AW];
  logic [7:0]  pg_lo [2**PAGE_W];
  logic [7:0]  pg_hi [2**PAGE_W];
  logic [7:0]  ee_pg [2**PAGE_W];
  logic [2**PAGE_W-1:0] ee_pg_vld_reg;
  logic [7:0]  lock_reg, fuse_lo_reg, fuse_hi_reg, fuse_ex_reg, ext_addr_reg;
  logic        en_reg, busy_reg;
  logic [23:0] wd_reg;
  logic [7:0]  b1, b2, b3, b4;
  logic [FLASH_AW-1:0] rd_addr;
  logic [EE_AW-1:0]    ee_addr;

  assign {b1, b2, b3, b4} = frame;
  assign rd_addr = FLASH_AW'({ext_addr_reg, b2, b3});
  assign ee_addr = EE_AW'({b2, b3});
  assign prog_en = en_reg;
  assign busy    = busy_reg;

  // Enable latch: only inside reset, cleared when reset is released
  always_ff @(posedge clk_sys) begin
    if (!resetn || !in_reset) begin
      en_reg <= 1'b0;
    end else if (frame_done && b1 == isp_pkg::OP_WRCFG && b2 == isp_pkg::SUB_ENABLE) begin
      en_reg <= 1'b1;
    end
  end

  // Write delay counter drives the pending flag
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wd_reg <= 24'h0;
    end else if (frame_done && en_reg && b1 == isp_pkg::OP_WRCFG && b2 == isp_pkg::SUB_ERASE) begin
      wd_reg <= 24'(isp_pkg::wd_cycles(isp_pkg::ERASE_WD_US, TIME_SCALE));
    end else if (frame_done && en_reg && b1 == isp_pkg::OP_WRCFG && b2 != isp_pkg::SUB_ENABLE) begin
      wd_reg <= 24'(isp_pkg::wd_cycles(isp_pkg::CONFIG_WD_US, TIME_SCALE));
    end else if (frame_done && en_reg && b1 == isp_pkg::OP_PAGE_WR) begin
      wd_reg <= 24'(isp_pkg::wd_cycles(isp_pkg::FLASH_WD_US, TIME_SCALE));
    end else if (frame_done && en_reg && (b1 == isp_pkg::OP_EE_WR || b1 == isp_pkg::OP_EE_PAGE_WR)) begin
      wd_reg <= 24'(isp_pkg::wd_cycles(isp_pkg::EEPROM_WD_US, TIME_SCALE));
    end else if (wd_reg != 24'h0) begin
      wd_reg <= wd_reg - 24'h1;
    end
  end

  // Registered so that the pending flag leaves the block from a flop
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busy_reg <= 1'b0;
    end else begin
      busy_reg <= (wd_reg != 24'h0);
    end
  end

  // Memory writes; contents are not reset, only erased by instruction
  always_ff @(posedge clk_sys) begin
    if (frame_done && en_reg) begin
      if (b1 == isp_pkg::OP_WRCFG && b2 == isp_pkg::SUB_ERASE) begin
        for (int i = 0; i < 2**FLASH_AW; i++) begin
          flash_lo[i] <= isp_pkg::ERASED;
          flash_hi[i] <= isp_pkg::ERASED;
        end
        for (int i = 0; i < 2**EE_AW; i++) begin
          eeprom[i] <= isp_pkg::ERASED;
        end
      end
      if (b1 == isp_pkg::OP_LOAD_LO) begin
        pg_lo[b3[PAGE_W-1:0]] <= b4;
      end
      if (b1 == isp_pkg::OP_LOAD_HI) begin
        pg_hi[b3[PAGE_W-1:0]] <= b4;
      end
      if (b1 == isp_pkg::OP_PAGE_WR) begin
        for (int i = 0; i < 2**PAGE_W; i++) begin
          flash_lo[{rd_addr[FLASH_AW-1:PAGE_W], PAGE_W'(i)}] <= pg_lo[i];
          flash_hi[{rd_addr[FLASH_AW-1:PAGE_W], PAGE_W'(i)}] <= pg_hi[i];
        end
      end
      if (b1 == isp_pkg::OP_EE_WR) begin
        eeprom[EE_AW'({b2, b3})] <= b4;
      end
      if (b1 == isp_pkg::OP_EE_LOAD) begin
        ee_pg[b3[PAGE_W-1:0]] <= b4;
      end
      if (b1 == isp_pkg::OP_EE_PAGE_WR) begin
        for (int i = 0; i < 2**PAGE_W; i++) begin
          if (ee_pg_vld_reg[i]) begin
            eeprom[{ee_addr[EE_AW-1:PAGE_W], PAGE_W'(i)}] <= ee_pg[i];
          end
        end
      end
    end
  end

  // Loaded-location marks for EEPROM page mode
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ee_pg_vld_reg <= '0;
    end else if (frame_done && en_reg && b1 == isp_pkg::OP_EE_PAGE_WR) begin
      ee_pg_vld_reg <= '0;
    end else if (frame_done && en_reg && b1 == isp_pkg::OP_EE_LOAD) begin
      ee_pg_vld_reg[b3[PAGE_W-1:0]] <= 1'b1;
    end
  end

  // Configuration bytes and extended address
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      lock_reg     <= isp_pkg::LOCK_RST;
      fuse_lo_reg  <= isp_pkg::FUSE_LO_RST;
      fuse_hi_reg  <= isp_pkg::FUSE_HI_RST;
      fuse_ex_reg  <= isp_pkg::FUSE_EX_RST;
      ext_addr_reg <= 8'h00;
    end else if (frame_done && en_reg) begin
      if (b1 == isp_pkg::OP_WRCFG) begin
        case (b2)
          isp_pkg::SUB_LOCK:     lock_reg    <= b4;
          isp_pkg::SUB_FUSE_LO:  fuse_lo_reg <= b4;
          isp_pkg::SUB_FUSE_HI:  fuse_hi_reg <= b4;
          isp_pkg::SUB_FUSE_EXT: fuse_ex_reg <= b4;
          isp_pkg::SUB_ERASE:    lock_reg    <= isp_pkg::LOCK_RST;
          default: ;
        endcase
      end
      if (b1 == isp_pkg::OP_EXT_ADDR) begin
        ext_addr_reg <= b3;
      end
    end
  end

  // ===========================================================================
  // Answer byte, chosen after byte three has been sampled
  logic [7:0] answer;
  logic [23:0] head;
  assign head = sh_reg[23:0];   // After 24 bits: b1 b2 b3

  always_comb begin
    answer = isp_pkg::BYTE_ZERO;
    case (head[23:16])
      isp_pkg::OP_POLL:      answer = {7'h0, busy};
      isp_pkg::OP_RD_LO:     answer = flash_lo[FLASH_AW'({ext_addr_reg, head[15:0]})];
      isp_pkg::OP_RD_HI:     answer = flash_hi[FLASH_AW'({ext_addr_reg, head[15:0]})];
      isp_pkg::OP_EE_RD:     answer = eeprom[EE_AW'(head[15:0])];
      isp_pkg::OP_RD_LOCKHI: answer = (head[15:8] == isp_pkg::SEL_HI) ? fuse_hi_reg : lock_reg;
      isp_pkg::OP_RD_FUSE:   answer = (head[15:8] == isp_pkg::SEL_HI) ? fuse_ex_reg : fuse_lo_reg;
      isp_pkg::OP_RD_CAL:    answer = isp_pkg::CAL_VALUE;
      isp_pkg::OP_RD_SIG: begin
        case (head[1:0])
          2'h0:    answer = isp_pkg::SIG0;
          2'h1:    answer = isp_pkg::SIG1;
          default: answer = isp_pkg::SIG2;
        endcase
      end
      default:               answer = isp_pkg::BYTE_ZERO;
    endcase
  end

  // MISO shift register: byte two echoes during byte three, answer in byte four
  always_ff @(posedge clk_sys) begin
    if (!resetn || !in_reset) begin
      out_reg  <= 8'h00;
      miso_reg <= 1'b0;
    end else if (sck_fall) begin
      if (bit_reg == 5'd16) begin
        out_reg  <= {sh_reg[6:0], 1'b0};
        miso_reg <= sh_reg[7];
      end else if (bit_reg == 5'd24) begin
        out_reg  <= {answer[6:0], 1'b0};
        miso_reg <= answer[7];
      end else begin
        out_reg  <= {out_reg[6:0], 1'b0};
        miso_reg <= out_reg[7];
      end
    end
  end

  assign link.miso = miso_reg;
endmodule // isp_dev

//--- hdl/isp_prog.sv
// Programmer end: sends 32-bit frames and returns the fourth answer byte
`timescale 1ns/1ps
module isp_prog #(
  parameter int POWERUP_CYC = isp_pkg::POWERUP_CYC   // Wait before enable
) (
  input  wire logic        clk_sys,    // Programmer clock
  input  wire logic        resetn,     // Synchronous reset, low
  isp_link_if.prog         link,       // Serial link pins
  input  wire logic        hold_rst,   // Keep target in programming reset
  input  wire logic        pulse_rst,  // Request a reset pulse for resync
  input  wire logic [31:0] cmd_data,   // Frame to send
  input  wire logic        cmd_valid,  // Frame offered
  output logic             cmd_ready,  // Frame accepted
  output logic [7:0]       rsp_echo,   // Byte received during byte three
  output logic [7:0]       rsp_data,   // Byte received during byte four
  output logic             rsp_valid,  // Answer ready, one cycle
  output logic             link_ready  // Power-up wait finished, idle
);
  typedef enum logic [3:0] {
    ST_WAIT  = 4'b0001,
    ST_IDLE  = 4'b0010,
    ST_SHIFT = 4'b0100,
    ST_PULSE = 4'b1000
  } isp_state_t;

  isp_state_t  st_reg;
  logic [31:0] q_data;
  logic        q_valid, q_take;
  logic [31:0] tx_reg;
  logic [31:0] rx_reg;
  logic [5:0]  bit_reg;
  logic [2:0]  div_reg;
  logic [23:0] cnt_reg;
  logic        sck_reg, rstn_pin_reg;
  logic [1:0]  miso_s_reg;

  // Buffer decouples the requester from the bit-level timing
  isp_buf2 #(.WIDTH(32)) u_buf (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .in_data   (cmd_data),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .out_data  (q_data),
    .out_valid (q_valid),
    .out_ready (q_take)
  );

  assign q_take = (st_reg == ST_IDLE) && q_valid && hold_rst && !pulse_rst;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      miso_s_reg <= 2'h0;
    end else begin
      miso_s_reg <= {miso_s_reg[0], link.miso};
    end
  end

  // ===========================================================================
  // Link sequencer; SCK half period keeps both phases over the minimum
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_reg       <= ST_WAIT;
      cnt_reg      <= 24'h0;
      div_reg      <= 3'h0;
      bit_reg      <= 6'h0;
      sck_reg      <= 1'b0;
      rstn_pin_reg <= 1'b0;
      tx_reg       <= 32'h0;
      rx_reg       <= 32'h0;
      rsp_valid    <= 1'b0;
      rsp_echo     <= 8'h00;
      rsp_data     <= 8'h00;
      link_ready   <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (st_reg)
        ST_WAIT: begin
          sck_reg      <= 1'b0;
          rstn_pin_reg <= 1'b0;
          if (cnt_reg == 24'(POWERUP_CYC - 1)) begin
            st_reg     <= ST_IDLE;
            link_ready <= 1'b1;
          end else begin
            cnt_reg <= cnt_reg + 24'h1;
          end
        end
        ST_IDLE: begin
          rstn_pin_reg <= !hold_rst;
          if (pulse_rst) begin
            st_reg       <= ST_PULSE;
            rstn_pin_reg <= 1'b1;
            cnt_reg      <= 24'h0;
            link_ready   <= 1'b0;
          end else if (q_take) begin
            tx_reg  <= q_data;
            bit_reg <= 6'h0;
            div_reg <= 3'h0;
            st_reg  <= ST_SHIFT;
            link_ready <= 1'b0;
          end
        end
        ST_SHIFT: begin
          if (div_reg == 3'(isp_pkg::SCK_HALF - 1)) begin
            div_reg <= 3'h0;
            sck_reg <= ~sck_reg;
            if (sck_reg) begin
              // MISO taken at the end of the high phase: both ends' synchronisers
              // leave too little of the low phase to sample it at the rise
              tx_reg  <= {tx_reg[30:0], 1'b0};
              rx_reg  <= {rx_reg[30:0], miso_s_reg[1]};
              bit_reg <= bit_reg + 6'h1;
              if (bit_reg == 6'd31) begin
                st_reg     <= ST_IDLE;
                rsp_echo   <= rx_reg[14:7];
                rsp_data   <= {rx_reg[6:0], miso_s_reg[1]};
                rsp_valid  <= 1'b1;
                link_ready <= 1'b1;
              end
            end
          end else begin
            div_reg <= div_reg + 3'h1;
          end
        end
        ST_PULSE: begin
          sck_reg <= 1'b0;
          if (cnt_reg == 24'(isp_pkg::RST_PULSE_CYC + 1)) begin
            rstn_pin_reg <= 1'b0;
            cnt_reg      <= 24'h0;
            st_reg       <= ST_WAIT;
          end else begin
            cnt_reg <= cnt_reg + 24'h1;
          end
        end
        default: st_reg <= ST_WAIT;
      endcase
    end
  end

  assign link.sck       = sck_reg;
  assign link.mosi      = tx_reg[31];
  assign link.rst_n_pin = rstn_pin_reg;
endmodule // isp_prog

//--- tb/isp_link_asserts.sv
// Concurrent checks on the serial link between programmer and device
`timescale 1ns/1ps
module isp_link_asserts (
  input wire logic clk_sys,   // System clock
  input wire logic resetn,    // Synchronous reset, low
  input wire logic rst_n_pin, // Target reset pin
  input wire logic sck,       // Serial clock
  input wire logic mosi,      // Data to device
  input wire logic miso,      // Data from device
  input wire logic prog_en,   // Programming enabled
  input wire logic busy       // Operation pending
);
  logic [4:0] bit_cnt_reg;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ===========================================================================
  // Frame position, cleared by system reset or a target reset pulse
  always_ff @(posedge clk_sys) begin
    if (!resetn || rst_n_pin)
      bit_cnt_reg <= 5'h00;
    else if (sck && !$past(sck))
      bit_cnt_reg <= bit_cnt_reg + 5'h01;
  end
  // ===========================================================================
  // Properties
  sequence s_high; sck [*3]; endsequence
  sequence s_low; !sck [*3]; endsequence
  property p_sck_high; $rose(sck) |-> s_high; endproperty
  property p_sck_low; $fell(sck) |-> s_low; endproperty
  property p_mosi_hold; $rose(sck) |-> $stable(mosi) [*3]; endproperty
  property p_miso_hold; sck && $past(sck) |-> $stable(miso); endproperty
  property p_sck_in_reset; rst_n_pin |-> !sck; endproperty
  property p_en_clear; rst_n_pin |-> ##[0:4] !prog_en; endproperty
  property p_en_rise; $rose(prog_en) |-> !rst_n_pin && bit_cnt_reg == 5'h00; endproperty
  property p_busy_cause; $rose(busy) |-> prog_en && bit_cnt_reg == 5'h00; endproperty
  a_sck_high: assert property (p_sck_high)
    else $error("SCK high phase too short");
  a_sck_low: assert property (p_sck_low)
    else $error("SCK low phase too short");
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("MOSI moved around the SCK rise");
  a_miso_hold: assert property (p_miso_hold)
    else $error("MISO moved while SCK high");
  a_sck_in_reset: assert property (p_sck_in_reset)
    else $error("SCK high while target out of reset");
  a_en_clear: assert property (p_en_clear)
    else $error("Programming mode kept after reset pulse");
  a_en_rise: assert property (p_en_rise)
    else $error("Programming mode entered off a frame boundary");
  a_busy_cause: assert property (p_busy_cause)
    else $error("Busy started outside a whole enabled frame");
endmodule // isp_link_asserts

//--- tb/tb_top.sv
// Testbench driving the programmer end against the device end
`timescale 1ns/1ps
module tb_top;
  logic        clk_sys   = 1'b0;
  logic        resetn    = 1'b0;
  logic        hold_rst  = 1'b1;
  logic        pulse_rst = 1'b0;
  logic [31:0] cmd_data  = 32'h0;
  logic        cmd_valid = 1'b0;
  logic        cmd_ready, rsp_valid, link_ready, prog_en, busy;
  logic [7:0]  rsp_echo, rsp_data;
  logic [31:0] q[$];
  logic [31:0] n;
  logic        full_seen = 1'b0;
  logic [7:0]  sub[4] = '{isp_pkg::SUB_FUSE_LO, isp_pkg::SUB_FUSE_HI, isp_pkg::SUB_FUSE_EXT, isp_pkg::SUB_LOCK};
  logic [7:0]  rb1[4] = '{isp_pkg::OP_RD_FUSE, isp_pkg::OP_RD_LOCKHI, isp_pkg::OP_RD_FUSE, isp_pkg::OP_RD_LOCKHI};
  logic [7:0]  rb2[4] = '{8'h00, isp_pkg::SEL_HI, isp_pkg::SEL_HI, 8'h00};
  logic [7:0]  sig[3] = '{isp_pkg::SIG0, isp_pkg::SIG1, isp_pkg::SIG2};
  int          errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  isp_link_if link_i ();
  isp_prog #(.POWERUP_CYC(20)) isp_prog_i (.clk_sys, .resetn, .link(link_i), .hold_rst, .pulse_rst, .cmd_data,
    .cmd_valid, .cmd_ready, .rsp_echo, .rsp_data, .rsp_valid, .link_ready);
  isp_dev #(.TIME_SCALE(1000)) isp_dev_i (.clk_sys, .resetn, .link(link_i), .prog_en, .busy);
  isp_link_asserts isp_link_asserts_i (.clk_sys, .resetn, .rst_n_pin(link_i.rst_n_pin), .sck(link_i.sck),
    .mosi(link_i.mosi), .miso(link_i.miso), .prog_en, .busy);
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  // ===========================================================================
  // Tasks
  task automatic end_sim();
    if (errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g, input logic [7:0] m);
    num_checks++;
    if ((g & m) !== (e & m)) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e & m, g);
    end
  endtask
  task automatic chk_flag(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
    end
  endtask
  // Note layout: echo mask, data mask, echo, data
  task automatic send(input logic [31:0] f, input logic [31:0] nt);
    int k;
    k = 0;
    cmd_data <= f;
    cmd_valid <= 1'b1;
    q.push_back(nt);
    @(posedge clk_sys);
    while (cmd_ready !== 1'b1 && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 3000)
      errors++;
  endtask
  task automatic rq(input logic [31:0] f, input logic [7:0] d);
    send(f, {16'hFFFF, f[23:16], d});
  endtask
  task automatic wq(input logic [31:0] f);
    send(f, {16'hFF00, f[23:16], 8'h00});
  endtask
  // Busy rises in the same cycle as the answer, so a drained queue already shows it
  task automatic drain();
    int k;
    k = 0;
    cmd_valid <= 1'b0;
    while (q.size() > 0 && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 3000)
      errors++;
  endtask
  task automatic idle();
    int k;
    k = 0;
    drain();
    repeat (8) @(posedge clk_sys);
    while (busy !== 1'b0 && k < 3000) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 3000)
      errors++;
  endtask
  // ===========================================================================
  // Answer watcher and hang limit
  always @(posedge clk_sys) begin
    cyc++;
    if (cmd_valid === 1'b1 && cmd_ready === 1'b0)
      full_seen <= 1'b1;
    if (rsp_valid === 1'b1) begin
      n = (q.size() > 0) ? q.pop_front() : 32'hFFFF_FFFF;
      chk_byte("echo", n[15:8], rsp_echo, n[31:24]);
      chk_byte("data", n[7:0], rsp_data, n[23:16]);
    end
    if (cyc == 60000) begin
      errors++;
      end_sim();
    end
  end
  // ===========================================================================
  // Main sequence
  initial begin
    logic [7:0] d[8];
    logic [5:0] p, a, b;
    int         i;
    void'($urandom(10));
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    send({isp_pkg::OP_WRCFG, isp_pkg::SUB_ERASE, 16'h0000}, 32'h0);
    drain();
    chk_flag("busy", 1'b0, busy);
    chk_flag("prog_en", 1'b0, prog_en);
    for (i = 0; i < 2; i++) begin
      wq({isp_pkg::OP_WRCFG, isp_pkg::SUB_ENABLE, 16'h0000});
      idle();
      chk_flag("prog_en", 1'b1, prog_en);
      chk_flag("link_ready", 1'b1, link_ready);
      if (i == 0) begin
        wq({isp_pkg::OP_WRCFG, isp_pkg::SUB_ERASE, 16'h0000});
        send({isp_pkg::OP_POLL, 24'h0}, 32'hFF01_0001);
        idle();
        send({isp_pkg::OP_POLL, 24'h0}, 32'hFF01_0000);
        a = 6'($urandom);
        p = 6'($urandom);
        rq({isp_pkg::OP_EE_RD, 10'h0, a, 8'h00}, isp_pkg::ERASED);
        rq({isp_pkg::OP_RD_LO, 8'h00, p, 2'b00, 8'h00}, isp_pkg::ERASED);
        for (int j = 0; j < 8; j++)
          d[j] = 8'($urandom);
        for (int j = 0; j < 4; j++) begin
          wq({isp_pkg::OP_LOAD_LO, 14'h0, 2'(j), d[j]});
          wq({isp_pkg::OP_LOAD_HI, 14'h0, 2'(j), d[j+4]});
        end
        wq({isp_pkg::OP_PAGE_WR, 8'h00, p, 2'b00, 8'h00});
        idle();
        for (int j = 0; j < 4; j++) begin
          rq({isp_pkg::OP_RD_LO, 8'h00, p, 2'(j), 8'h00}, d[j]);
          rq({isp_pkg::OP_RD_HI, 8'h00, p, 2'(j), 8'h00}, d[j+4]);
        end
        wq({isp_pkg::OP_EE_WR, 10'h0, a, d[0]});
        idle();
        wq({isp_pkg::OP_EE_WR, 10'h0, a, ~d[0]});
        idle();
        b = {a[5:2], a[1:0] + 2'd1};
        wq({isp_pkg::OP_EE_LOAD, 14'h0, b[1:0], d[1]});
        wq({isp_pkg::OP_EE_PAGE_WR, 10'h0, a[5:2], 2'b00, 8'h00});
        idle();
        rq({isp_pkg::OP_EE_RD, 10'h0, a, 8'h00}, ~d[0]);
        rq({isp_pkg::OP_EE_RD, 10'h0, b, 8'h00}, d[1]);
        idle();
        for (int j = 0; j < 4; j++) begin
          wq({isp_pkg::OP_WRCFG, sub[j], 8'h00, d[j+2]});
          idle();
          rq({rb1[j], rb2[j], 16'h0000}, d[j+2]);
          idle();
        end
        for (int j = 0; j < 3; j++)
          rq({isp_pkg::OP_RD_SIG, 8'h00, 8'(j), 8'h00}, sig[j]);
        rq({isp_pkg::OP_RD_CAL, 24'h0}, isp_pkg::CAL_VALUE);
        idle();
        chk_flag("refused", 1'b1, full_seen);
        pulse_rst <= 1'b1;
        @(posedge clk_sys);
        pulse_rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk_flag("link_ready", 1'b0, link_ready);
        repeat (38) @(posedge clk_sys);
        chk_flag("prog_en", 1'b0, prog_en);
      end
    end
    end_sim();
  end
endmodule // tb_top
